// >>> common/psm_pkg.sv
// Package: constants and carrier types of the power-saving mode controller
package psm_pkg;

	// Register addresses
	localparam logic [7:0] PSM_ADDR_PWR_CTRL = 8'h87;
	localparam logic [7:0] PSM_ADDR_PWR_EXT  = 8'h88;
	localparam logic [7:0] PSM_ADDR_SYS_CFG  = 8'hB1;
	localparam logic [7:0] PSM_ADDR_STATUS   = 8'hB3;

	// Field positions in power_ctrl_reg
	localparam int PSM_BIT_IDLE_EN  = 0;
	localparam int PSM_BIT_PD_ARM   = 1;
	localparam int PSM_BIT_GF0      = 2;
	localparam int PSM_BIT_GF1      = 3;
	localparam int PSM_BIT_IDLE_GO  = 5;
	localparam int PSM_BIT_PD_GO    = 6;
	localparam int PSM_BIT_SMOD     = 7;
	// Field positions in power_ctrl_ext_reg and sys_cfg_reg
	localparam int PSM_BIT_WAKE_EN  = 7;
	localparam int PSM_BIT_REMAP    = 4;

	// Reset values
	localparam logic [7:0] PSM_SYS_CFG_RST = 8'h00;
	localparam logic       PSM_WAKE_EN_RST = 1'b0;

	// Timing: clock period and documented times
	localparam int PSM_CLK_PS       = 4000;
	localparam int PSM_LATCH_NS     = 10000;
	localparam int PSM_WAKE_DLY_US  = 5000;
	// Least time rounds up
	localparam int PSM_LATCH_CYC    = (PSM_LATCH_NS * 1000 + PSM_CLK_PS - 1) / PSM_CLK_PS;
	localparam int PSM_WAKE_DLY_CYC = (PSM_WAKE_DLY_US * 1000) / (PSM_CLK_PS / 1000);
	localparam int PSM_CNT_W        = 21;

	// Wake-up interrupt vector
	localparam logic [15:0] PSM_WAKE_VECTOR = 16'h007B;

	// Mode states, Gray along run, pd, wake path
	typedef enum logic [2:0] {
		PSM_RUN    = 3'h0,
		PSM_PD     = 3'h1,
		PSM_WLATCH = 3'h3,
		PSM_WOSC   = 3'h2,
		PSM_WDLY   = 3'h6,
		PSM_WISR   = 3'h7,
		PSM_IDLE   = 3'h4
	} psm_state_t;

	// Register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} psm_bus_req_t;

	// Clock and freeze controls towards the chip
	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic wdt_run;
		logic timers_freeze;
		logic rc_osc_en;
		logic xtal_osc_en;
		logic alt_hold;
		logic irq_block;
		logic wake_irq;
	} psm_ctl_t;

endpackage

// >>> rtl/psm_ctrl.sv
// Power-saving mode controller: idle and power-down entry, wake-up, pin states
// Function
// - Idle enters on enable write then start write
// - Both idle bits together never start idle
// - Idle bits self-clear and read as zero
// - Idle stops CPU clock and watchdog; peripherals keep running
// - Enabled interrupt ends idle, resumes after return
// - Power-down stops both oscillators, keeps state
// - Power-down keeps port and alternate output values
// - Power-down drives address and store strobes low
// - Power-down enters on arm write then start
// - Both power-down bits together never start it
// - Power-down bits self-clear and read as zero
// - Wake disabled: only reset leaves power-down
// - Reset leaving power-down resets registers, restarts oscillators
// - Wake pin low leaves power-down, RC samples
// - After crystal stable wait 5ms, vector 007B
// - Timers and watchdog frozen until wake return
// - Other interrupts blocked until wake routine returns
// - Start write is last instruction before mode
// - Simultaneous idle and power-down picks power-down
// - Wake enable at 88h under remap bit
// - Idle holds address and store strobes high
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module psm_ctrl #(
	parameter int DLY_CYC = psm_pkg::PSM_WAKE_DLY_CYC    // Post-stable wake delay
) (
	input  wire logic                mclk,          // 250 MHz clock
	input  wire logic                reset,         // Async reset, active high
	input  wire psm_pkg::psm_bus_req_t bus,         // Register bus request
	output logic [7:0]               rdata,         // Read data, cycle after rd
	input  wire logic                instr_done,    // Pulse per retired instruction
	input  wire logic                irq_pending,   // Enabled interrupt pending
	input  wire logic                return_from_interrupt,          // Return from interrupt pulse
	input  wire logic                xtal_stable,   // Crystal detected stable
	input  wire logic                wake_pin_n,    // External wake pin
	input  wire logic                cpu_ale,       // Strobe from core
	input  wire logic                cpu_prog_store_strobe_n_n,    // Store strobe from core
	output logic                     addr_latch_strobe,   // Pin value
	output logic                     prog_store_strobe_n, // Pin value
	output psm_pkg::psm_ctl_t        ctl,           // Clock and freeze controls
	output logic [15:0]              wake_vector    // Vector for wake interrupt
);
	import psm_pkg::*;

	// Whole state of the block
	typedef struct packed {
		psm_state_t             st;
		logic                   smod;
		logic                   gf1;
		logic                   gf0;
		logic [7:0]             sys_cfg;
		logic                   ext_wake_enable;
		logic                   idle_armed;
		logic                   pd_armed;
		logic                   wake_ok;
		logic [PSM_CNT_W-1:0]   cnt;
		logic [7:0]             rdata;
		logic                   ale;
		logic                   prog_store_strobe_n_n;
		psm_ctl_t               ctl;
		logic [1:0]             pin_sync;
	} psm_regs_t;

	psm_regs_t r;
	psm_regs_t next_r;

	// Two-write sequence: returns {enter, next_armed}
	function automatic logic [1:0] psm_seq(input logic armed, input logic arm_b,
		input logic go_b);
		logic enter;
		logic nxt;
		enter = armed && go_b && !arm_b;
		nxt   = arm_b && !go_b;
		return {enter, nxt};
	endfunction

	logic       power_ctrl_reg_wr;
	logic       ext_wr;
	logic [1:0] idle_q;
	logic [1:0] pd_q;
	logic       pin_low;

	// Decode of writes and sequence evaluation
	always_comb begin
		power_ctrl_reg_wr = bus.wr && bus.addr == PSM_ADDR_PWR_CTRL;
		ext_wr  = bus.wr && bus.addr == PSM_ADDR_PWR_EXT && r.sys_cfg[PSM_BIT_REMAP];
		idle_q  = psm_seq(r.idle_armed, bus.wdata[PSM_BIT_IDLE_EN],
			bus.wdata[PSM_BIT_IDLE_GO]);
		pd_q    = psm_seq(r.pd_armed, bus.wdata[PSM_BIT_PD_ARM],
			bus.wdata[PSM_BIT_PD_GO]);
		pin_low = !r.pin_sync[1];
	end

	// Next-state logic
	always_comb begin
		next_r = r;
		next_r.pin_sync = {r.pin_sync[0], wake_pin_n};
		next_r.rdata = 8'h00;

		// Any other instruction or write breaks an armed sequence
		if (instr_done || bus.wr) begin
			next_r.idle_armed = 1'b0;
			next_r.pd_armed   = 1'b0;
		end

		// Register writes; start and enable bits are never stored
		if (power_ctrl_reg_wr && r.st == PSM_RUN || power_ctrl_reg_wr && r.st == PSM_WISR) begin
			next_r.smod = bus.wdata[PSM_BIT_SMOD];
			next_r.gf1  = bus.wdata[PSM_BIT_GF1];
			next_r.gf0  = bus.wdata[PSM_BIT_GF0];
			next_r.idle_armed = idle_q[0];
			next_r.pd_armed   = pd_q[0];
		end
		if (ext_wr) begin
			next_r.ext_wake_enable = bus.wdata[PSM_BIT_WAKE_EN];
		end
		if (bus.wr && bus.addr == PSM_ADDR_SYS_CFG) begin
			next_r.sys_cfg = bus.wdata;
		end

		// Reads: arm and start bits always read zero
		if (bus.rd) begin
			if (bus.addr == PSM_ADDR_PWR_CTRL) begin
				next_r.rdata[PSM_BIT_SMOD] = r.smod;
				next_r.rdata[PSM_BIT_GF1]  = r.gf1;
				next_r.rdata[PSM_BIT_GF0]  = r.gf0;
			end else if (bus.addr == PSM_ADDR_PWR_EXT && r.sys_cfg[PSM_BIT_REMAP]) begin
				next_r.rdata[PSM_BIT_WAKE_EN] = r.ext_wake_enable;
			end else if (bus.addr == PSM_ADDR_SYS_CFG) begin
				next_r.rdata = r.sys_cfg;
			end else if (bus.addr == PSM_ADDR_STATUS) begin
				next_r.rdata = {3'h0, r.pd_armed, r.idle_armed, r.st};
			end
		end

		// Mode sequencing
		case (r.st)
			PSM_RUN: begin
				// The start write is the last thing done before the mode
				if (power_ctrl_reg_wr && pd_q[1]) begin
					next_r.st = PSM_PD;
					next_r.wake_ok = r.ext_wake_enable;
				end else if (power_ctrl_reg_wr && idle_q[1]) begin
					next_r.st = PSM_IDLE;
				end
			end
			PSM_IDLE: begin
				if (irq_pending) begin
					next_r.st = PSM_RUN;
				end
			end
			PSM_PD: begin
				// Without wake enable only reset leaves this state
				if (r.wake_ok && pin_low) begin
					next_r.st  = PSM_WLATCH;
					next_r.cnt = '0;
				end
			end
			PSM_WLATCH: begin
				// Pin must stay low for the whole latch phase
				if (!pin_low) begin
					next_r.st = PSM_PD;
				end else if (r.cnt == PSM_CNT_W'(PSM_LATCH_CYC - 1)) begin
					next_r.st = PSM_WOSC;
				end else begin
					next_r.cnt = r.cnt + 1'b1;
				end
			end
			PSM_WOSC: begin
				if (xtal_stable) begin
					next_r.st  = PSM_WDLY;
					next_r.cnt = '0;
				end
			end
			PSM_WDLY: begin
				if (r.cnt == PSM_CNT_W'(DLY_CYC - 1)) begin
					next_r.st = PSM_WISR;
				end else begin
					next_r.cnt = r.cnt + 1'b1;
				end
			end
			PSM_WISR: begin
				if (return_from_interrupt) begin
					next_r.st = PSM_RUN;
				end
			end
			default: begin
				next_r.st = PSM_RUN;
			end
		endcase

		// Controls follow the next state so outputs switch with it
		next_r.ctl = '0;
		next_r.ale = cpu_ale;
		next_r.prog_store_strobe_n_n = cpu_prog_store_strobe_n_n;
		case (next_r.st)
			PSM_RUN: begin
				next_r.ctl.cpu_clk_en    = 1'b1;
				next_r.ctl.periph_clk_en = 1'b1;
				next_r.ctl.wdt_run       = 1'b1;
				next_r.ctl.rc_osc_en     = 1'b1;
				next_r.ctl.xtal_osc_en   = 1'b1;
			end
			PSM_IDLE: begin
				// Watchdog is the only peripheral stopped
				next_r.ctl.periph_clk_en = 1'b1;
				next_r.ctl.rc_osc_en     = 1'b1;
				next_r.ctl.xtal_osc_en   = 1'b1;
				next_r.ale    = 1'b1;
				next_r.prog_store_strobe_n_n = 1'b1;
			end
			PSM_PD: begin
				// Everything stopped; ports hold latch and last alt values
				next_r.ctl.alt_hold      = 1'b1;
				next_r.ctl.timers_freeze = 1'b1;
				next_r.ale    = 1'b0;
				next_r.prog_store_strobe_n_n = 1'b0;
			end
			PSM_WLATCH, PSM_WOSC, PSM_WDLY: begin
				// RC clock runs from the pin going low
				next_r.ctl.alt_hold      = 1'b1;
				next_r.ctl.timers_freeze = 1'b1;
				next_r.ctl.irq_block     = 1'b1;
				next_r.ctl.rc_osc_en     = 1'b1;
				next_r.ctl.xtal_osc_en   = (next_r.st != PSM_WLATCH);
				next_r.ale    = 1'b0;
				next_r.prog_store_strobe_n_n = 1'b0;
			end
			PSM_WISR: begin
				next_r.ctl.cpu_clk_en    = 1'b1;
				next_r.ctl.periph_clk_en = 1'b1;
				next_r.ctl.timers_freeze = 1'b1;
				next_r.ctl.irq_block     = 1'b1;
				next_r.ctl.wake_irq      = 1'b1;
				next_r.ctl.rc_osc_en     = 1'b1;
				next_r.ctl.xtal_osc_en   = 1'b1;
			end
			default: begin
				next_r.ctl.cpu_clk_en = 1'b1;
			end
		endcase
	end

	// State register; reset restarts both oscillators and clears registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r.st              <= PSM_RUN;
			r.smod            <= 1'b0;
			r.gf1             <= 1'b0;
			r.gf0             <= 1'b0;
			r.sys_cfg         <= PSM_SYS_CFG_RST;
			r.ext_wake_enable <= PSM_WAKE_EN_RST;
			r.idle_armed      <= 1'b0;
			r.pd_armed        <= 1'b0;
			r.wake_ok         <= 1'b0;
			r.cnt             <= '0;
			r.rdata           <= 8'h00;
			r.ale             <= 1'b0;
			r.prog_store_strobe_n_n          <= 1'b1;
			r.ctl             <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
				wdt_run: 1'b1, rc_osc_en: 1'b1, xtal_osc_en: 1'b1, default: 1'b0};
			r.pin_sync        <= 2'h3;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from flops, wake vector from the package constant
	always_comb begin
		rdata               = r.rdata;
		addr_latch_strobe   = r.ale;
		prog_store_strobe_n = r.prog_store_strobe_n_n;
		ctl                 = r.ctl;
		wake_vector         = PSM_WAKE_VECTOR;
	end

endmodule

`default_nettype wire

// >>> testbench/psm_ctrl_assertions.sv
// Checker: port properties of the power-saving mode controller
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_assertions
	import psm_pkg::*;
#(
	parameter int DLY_CYC = PSM_WAKE_DLY_CYC // Wake delay
) (
	input wire logic                  mclk,                // Clock
	input wire logic                  reset,               // Reset
	input wire psm_pkg::psm_bus_req_t bus,                 // Bus
	input wire logic [7:0]            rdata,               // Read data
	input wire logic                  instr_done,          // Retire
	input wire logic                  irq_pending,         // Interrupt
	input wire logic                  return_from_interrupt,                // Return
	input wire logic                  xtal_stable,         // Stable
	input wire logic                  wake_pin_n,          // Wake pin
	input wire logic                  cpu_ale,             // Core
	input wire logic                  cpu_prog_store_strobe_n_n,          // Core
	input wire logic                  addr_latch_strobe,   // Pin
	input wire logic                  prog_store_strobe_n, // Pin
	input wire psm_pkg::psm_ctl_t     ctl,                 // Controls
	input wire logic [15:0]           wake_vector          // Vector
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Mode views; irq_block excludes the wake path
	logic run;
	logic idle;
	logic down;
	assign run = ctl.cpu_clk_en && ctl.xtal_osc_en && !ctl.irq_block && !ctl.timers_freeze;
	assign idle = !ctl.cpu_clk_en && ctl.periph_clk_en && !ctl.irq_block;
	assign down = !ctl.xtal_osc_en && !ctl.rc_osc_en;
	// Exact power-control write, no retire beside it
	sequence s_pw(logic [7:0] d);
		bus.wr && bus.addr == PSM_ADDR_PWR_CTRL && bus.wdata == d && !instr_done;
	endsequence
	property p_idle_go;
		run ##0 s_pw(8'h01) ##1 s_pw(8'h20) |=> idle && !ctl.wdt_run;
	endproperty
	a_idle_go: assert property (p_idle_go) else $error("idle not entered");
	property p_idle_both;
		run ##0 s_pw(8'h21) |=> ctl.cpu_clk_en;
	endproperty
	a_idle_both: assert property (p_idle_both) else $error("idle from one write");
	property p_pd_go;
		run ##0 s_pw(8'h02) ##1 s_pw(8'h40) |=> down && ctl.alt_hold;
	endproperty
	a_pd_go: assert property (p_pd_go) else $error("power-down not entered");
	property p_pd_first;
		run ##0 s_pw(8'h03) ##1 s_pw(8'h60) |=> down;
	endproperty
	a_pd_first: assert property (p_pd_first) else $error("idle taken over power-down");
	property p_pd_both;
		run ##0 s_pw(8'h62) |=> ctl.xtal_osc_en;
	endproperty
	a_pd_both: assert property (p_pd_both) else $error("power-down from one write");
	property p_rd_zero;
		bus.rd && bus.addr == PSM_ADDR_PWR_CTRL |=> rdata[6:5] == 2'h0 && rdata[1:0] == 2'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("start bits read back");
	property p_idle_pins;
		idle |-> addr_latch_strobe && prog_store_strobe_n;
	endproperty
	a_idle_pins: assert property (p_idle_pins) else $error("idle strobes not high");
	property p_pd_pins;
		down |-> !addr_latch_strobe && !prog_store_strobe_n;
	endproperty
	a_pd_pins: assert property (p_pd_pins) else $error("down strobes not low");
	property p_idle_exit;
		idle && irq_pending |-> ##[1:2] ctl.cpu_clk_en;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
	property p_wake_hold;
		ctl.wake_irq |-> ctl.irq_block && ctl.timers_freeze && ctl.cpu_clk_en;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake routine unguarded");
	property p_vector;
		wake_vector == PSM_WAKE_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("wake vector wrong");
	// Main scenarios reached
	c_idle: cover property (run ##0 s_pw(8'h01) ##1 s_pw(8'h20));
	c_pd: cover property (run ##0 s_pw(8'h02) ##1 s_pw(8'h40));
	c_wake: cover property (ctl.wake_irq ##1 !ctl.wake_irq);
endmodule
bind psm_ctrl psm_ctrl_assertions #(.DLY_CYC(DLY_CYC)) u_chk (.mclk(mclk), .reset(reset),
	.bus(bus), .rdata(rdata), .instr_done(instr_done), .irq_pending(irq_pending),
	.return_from_interrupt(return_from_interrupt), .xtal_stable(xtal_stable), .wake_pin_n(wake_pin_n), .cpu_ale(cpu_ale),
	.cpu_prog_store_strobe_n_n(cpu_prog_store_strobe_n_n), .addr_latch_strobe(addr_latch_strobe),
	.prog_store_strobe_n(prog_store_strobe_n), .ctl(ctl), .wake_vector(wake_vector));
`default_nettype wire

// >>> testbench/psm_ext_party.sv
// Partner model: external reset and wake pin driver
`timescale 1ns/1ps
`default_nettype none
module psm_ext_party (
	input  wire logic mclk,      // Clock
	output logic      reset,     // Reset to device
	output logic      wake_pin_n // Wake pin, parked high
);
	// Pin parked high so entry does not wake at once
	initial begin
		reset = 1'b1;
		wake_pin_n = 1'b1;
	end
	// Reset for whole cycles; two suffice while the crystal runs
	task automatic rst(input int n);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (n) @(posedge mclk);
		reset <= 1'b0;
	endtask
	// Wake pulse; length covers the latch phase
	task automatic pulse(input int n);
		@(posedge mclk);
		wake_pin_n <= 1'b0;
		repeat (n) @(posedge mclk);
		wake_pin_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> testbench/psm_ctrl_tb.sv
// Testbench: scenarios for the power-saving mode controller
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_tb;
	import psm_pkg::*;
	logic         mclk;
	logic         reset;
	logic         wake_pin_n;
	psm_bus_req_t bus;
	logic [7:0]   rdata;
	logic         irq_pending;
	logic         return_from_interrupt;
	logic         xtal_stable;
	logic         instr_done;
	logic         cpu_ale;
	logic         cpu_prog_store_strobe_n_n;
	logic         ale;
	logic         prog_store_strobe_n_n;
	psm_ctl_t     ctl;
	logic [15:0]  wake_vector;
	int           n_errors;
	int           comparisons;
	// Short wake delay keeps the run brief
	psm_ctrl #(.DLY_CYC(20)) dut (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
		.instr_done(instr_done), .irq_pending(irq_pending), .return_from_interrupt(return_from_interrupt),
		.xtal_stable(xtal_stable), .wake_pin_n(wake_pin_n), .cpu_ale(cpu_ale),
		.cpu_prog_store_strobe_n_n(cpu_prog_store_strobe_n_n), .addr_latch_strobe(ale), .prog_store_strobe_n(prog_store_strobe_n_n),
		.ctl(ctl), .wake_vector(wake_vector));
	psm_ext_party ext (.mclk(mclk), .reset(reset), .wake_pin_n(wake_pin_n));
	// Clock and time-zero inputs
	initial begin
		mclk = 1'b0;
		bus = '0;
		irq_pending = 1'b0;
		return_from_interrupt = 1'b0;
		xtal_stable = 1'b0;
		instr_done = 1'b0;
		cpu_ale = 1'b0;
		cpu_prog_store_strobe_n_n = 1'b1;
	end
	always #2 mclk = ~mclk;
	// Crystal reports stable a cycle after it is enabled
	always @(posedge mclk) xtal_stable <= ctl.xtal_osc_en;
	task automatic chkb(input string nm, input logic ex, input logic got);
		comparisons++;
		if (got !== ex) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", nm, ex, got);
		end
	endtask
	task automatic chkv(input string nm, input logic [15:0] ex, input logic [15:0] got);
		comparisons++;
		if (got !== ex) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Bus cycles; idle ends off the edge so checks see settled values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge mclk);
			bus <= '0;
		end
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
		@(posedge mclk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		idle(1);
		chkv("rdata", {8'h00, ex}, {8'h00, rdata & m});
	endtask
	// Both sequences at once must land in power-down, not idle
	task automatic s_pd_reset();
		wr(PSM_ADDR_PWR_CTRL, 8'h03);
		wr(PSM_ADDR_PWR_CTRL, 8'h60);
		idle(3);
		chkb("periph_clk_en", 1'b0, ctl.periph_clk_en);
		ext.pulse(2600);
		idle(3);
		chkb("xtal_osc_en", 1'b0, ctl.xtal_osc_en);
		chkb("rc_osc_en", 1'b0, ctl.rc_osc_en);
		ext.rst(2);
		idle(2);
		chkb("xtal_osc_en", 1'b1, ctl.xtal_osc_en);
		chkb("rc_osc_en", 1'b1, ctl.rc_osc_en);
	endtask
	// Core strobes pass in run; idle must override them
	task automatic s_idle();
		@(posedge mclk);
		cpu_ale <= 1'b1;
		cpu_prog_store_strobe_n_n <= 1'b0;
		idle(2);
		chkb("ale", 1'b1, ale);
		chkb("prog_store_strobe_n_n", 1'b0, prog_store_strobe_n_n);
		@(posedge mclk);
		cpu_ale <= 1'b0;
		wr(PSM_ADDR_PWR_CTRL, 8'h01);
		wr(PSM_ADDR_PWR_CTRL, 8'h20);
		idle(3);
		chkb("cpu_clk_en", 1'b0, ctl.cpu_clk_en);
		chkb("wdt_run", 1'b0, ctl.wdt_run);
		chkb("periph_clk_en", 1'b1, ctl.periph_clk_en);
		chkb("ale", 1'b1, ale);
		chkb("prog_store_strobe_n_n", 1'b1, prog_store_strobe_n_n);
		@(posedge mclk);
		irq_pending <= 1'b1;
		idle(3);
		chkb("cpu_clk_en", 1'b1, ctl.cpu_clk_en);
		@(posedge mclk);
		irq_pending <= 1'b0;
		cpu_ale <= 1'b1;
		cpu_prog_store_strobe_n_n <= 1'b1;
		rd(PSM_ADDR_PWR_CTRL, 8'h00, 8'hFF);
	endtask
	task automatic s_refuse();
		wr(PSM_ADDR_PWR_CTRL, 8'h21);
		idle(3);
		chkb("cpu_clk_en", 1'b1, ctl.cpu_clk_en);
		wr(PSM_ADDR_PWR_CTRL, 8'h62);
		idle(3);
		chkb("xtal_osc_en", 1'b1, ctl.xtal_osc_en);
		wr(PSM_ADDR_PWR_CTRL, 8'h01);
		wr(PSM_ADDR_SYS_CFG, 8'h00);
		wr(PSM_ADDR_PWR_CTRL, 8'h20);
		idle(3);
		chkb("cpu_clk_en", 1'b1, ctl.cpu_clk_en);
		// Armed bit reads zero; a retired instruction then disarms
		wr(PSM_ADDR_PWR_CTRL, 8'h02);
		rd(PSM_ADDR_PWR_CTRL, 8'h00, 8'hFF);
		@(posedge mclk);
		instr_done <= 1'b1;
		@(posedge mclk);
		instr_done <= 1'b0;
		wr(PSM_ADDR_PWR_CTRL, 8'h40);
		idle(3);
		chkb("xtal_osc_en", 1'b1, ctl.xtal_osc_en);
	endtask
	// Wake enable reachable only under the remap bit
	task automatic s_map();
		rd(PSM_ADDR_PWR_EXT, 8'h00, 8'hFF);
		rd(8'h90, 8'h00, 8'hFF);
		wr(PSM_ADDR_SYS_CFG, 8'h10);
		wr(PSM_ADDR_PWR_EXT, 8'h80);
		rd(PSM_ADDR_PWR_EXT, 8'h80, 8'h80);
		wr(PSM_ADDR_SYS_CFG, 8'h00);
		wr(PSM_ADDR_PWR_EXT, 8'h00);
		rd(PSM_ADDR_SYS_CFG, 8'h00, 8'hFF);
		wr(PSM_ADDR_SYS_CFG, 8'h10);
		rd(PSM_ADDR_PWR_EXT, 8'h80, 8'h80);
		wr(PSM_ADDR_SYS_CFG, 8'h00);
		idle(1);
	endtask
	task automatic s_pd_wake();
		int i;
		wr(PSM_ADDR_PWR_CTRL, 8'h02);
		wr(PSM_ADDR_PWR_CTRL, 8'h40);
		idle(3);
		chkb("rc_osc_en", 1'b0, ctl.rc_osc_en);
		chkb("prog_store_strobe_n_n", 1'b0, prog_store_strobe_n_n);
		chkb("ale", 1'b0, ale);
		chkb("alt_hold", 1'b1, ctl.alt_hold);
		ext.pulse(2600);
		for (i = 0; i < 200 && ctl.wake_irq !== 1'b1; i++) idle(1);
		if (ctl.wake_irq !== 1'b1) begin
			n_errors++;
			final_report();
		end
		chkb("irq_block", 1'b1, ctl.irq_block);
		chkb("timers_freeze", 1'b1, ctl.timers_freeze);
		chkb("wdt_run", 1'b0, ctl.wdt_run);
		chkv("wake_vector", 16'h007B, wake_vector);
		@(posedge mclk);
		return_from_interrupt <= 1'b1;
		@(posedge mclk);
		return_from_interrupt <= 1'b0;
		idle(2);
		chkb("wake_irq", 1'b0, ctl.wake_irq);
		chkb("irq_block", 1'b0, ctl.irq_block);
	endtask
	task automatic final_report();
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		ext.rst(6);
		s_pd_reset();
		s_idle();
		s_refuse();
		s_map();
		s_pd_wake();
		final_report();
	end
endmodule
`default_nettype wire
